/* hsctl_params.svh */
`ifndef HSCTL_PARAMS_SVH
`define HSCTL_PARAMS_SVH

// Register byte offsets
`define HSCTL_CTRL_OFS     8'h00
`define HSCTL_STAT_OFS     8'h04

// Control register field positions
`define HSCTL_MODE_LSB     0
`define HSCTL_RTS_LSB      4
`define HSCTL_CTS_BIT      8
`define HSCTL_DCD_BIT      9
`define HSCTL_DTR_BIT      10
`define HSCTL_DSR_BIT      11

// Status register field positions
`define HSCTL_ST_RTS_BIT   0
`define HSCTL_ST_CTS_BIT   1
`define HSCTL_ST_DCD_BIT   2
`define HSCTL_ST_DTR_BIT   3
`define HSCTL_ST_DSR_BIT   4
`define HSCTL_ST_EN_BIT    5
`define HSCTL_ST_TEST_LSB  8

// Mode codes and reset values
`define HSCTL_MODE_OFF     4'h0
`define HSCTL_MODE_MAX     4'h9
`define HSCTL_CTRL_RST     32'h0000_0000

// Bus responses
`define HSCTL_RESP_OKAY    2'h0
`define HSCTL_RESP_SLVERR  2'h2
`define HSCTL_RESP_DECERR  2'h3

`endif

/* hsctl_pkg.sv */
package hsctl_pkg;

	// Request-to-send handling
	typedef enum logic [1:0] {
		HSCTL_RTS_NORMAL  = 2'h0,
		HSCTL_RTS_CARRIER = 2'h1,
		HSCTL_RTS_IGNORE  = 2'h2
	} hsctl_rts_type;

	// Software control settings
	typedef struct packed {
		logic          dsr_force;
		logic          dtr_ignore;
		logic          dcd_force;
		logic          cts_force;
		hsctl_rts_type rts;
		logic [3:0]    mode;
	} hsctl_ctrl_type;

	// Live handshake line states
	typedef struct packed {
		logic rts;
		logic cts;
		logic dcd;
		logic dtr;
		logic dsr;
	} hsctl_line_type;

endpackage

/* hsctl_line_if.sv */
`timescale 1ns/1ps
interface hsctl_line_if;
	import hsctl_pkg::*;

	hsctl_ctrl_type ctrl;
	hsctl_line_type live;

	modport regs  (output ctrl, input live);
	modport lines (input ctrl, output live);
endinterface

/* hsctl_lines.sv */
`timescale 1ns/1ps
module hsctl_lines
	import hsctl_pkg::*;
(
	input  wire logic     aclk,
	input  wire logic     aresetn,
	input  wire logic     rts_pin,
	input  wire logic     dtr_pin,
	input  wire logic     rx_carrier_ok,
	input  wire logic     tx_ready,
	hsctl_line_if.lines   bus,
	output logic          cts_pin,
	output logic          dcd_pin,
	output logic          dsr_pin,
	output logic          transmit_carrier
);
	`include "hsctl_params.svh"

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic       cts;
		logic       dcd;
		logic       dsr;
		logic       carrier;
	} hsctl_lines_type;

	hsctl_lines_type r, nxt;
	logic            en;
	logic            rts_on;
	logic            dtr_ok;

	// Line qualifiers; forced settings bypass the enable on purpose
	always_comb begin
		en     = bus.ctrl.mode != `HSCTL_MODE_OFF;
		rts_on = (bus.ctrl.rts == HSCTL_RTS_IGNORE) | r.sync[1];
		dtr_ok = bus.ctrl.dtr_ignore | r.sync[0];
	end

	// Next state; meta is read only by sync
	always_comb begin
		nxt         = r;
		nxt.meta    = {rts_pin, dtr_pin};
		nxt.sync    = r.meta;
		nxt.cts     = bus.ctrl.cts_force | (en & dtr_ok & rts_on & tx_ready);
		nxt.dcd     = bus.ctrl.dcd_force | (en & rx_carrier_ok);
		nxt.dsr     = bus.ctrl.dsr_force | (en & dtr_ok);
		nxt.carrier = en & dtr_ok &
			((bus.ctrl.rts != HSCTL_RTS_CARRIER) | r.sync[1]);
	end

	// Each line has its own flop; the DTR and RTS settings still feed several lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	// Outputs and live status
	assign cts_pin          = r.cts;
	assign dcd_pin          = r.dcd;
	assign dsr_pin          = r.dsr;
	assign transmit_carrier = r.carrier;
	assign bus.live         = '{rts: r.sync[1], cts: r.cts, dcd: r.dcd,
		dtr: r.sync[0], dsr: r.dsr};

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence rts_held_s;
		rts_pin [*3];
	endsequence

	sequence dtr_held_s;
		dtr_pin [*3];
	endsequence

	cts_force_a: assert property (bus.ctrl.cts_force |=> cts_pin)
		else $error("cts not forced");
	dcd_force_a: assert property (bus.ctrl.dcd_force |=> dcd_pin)
		else $error("dcd not forced");
	dsr_force_a: assert property (bus.ctrl.dsr_force |=> dsr_pin)
		else $error("dsr not forced");
	dtr_ignore_a: assert property (bus.ctrl.dtr_ignore && en |=> dsr_pin)
		else $error("dtr not ignored");
	dtr_honour_a: assert property (!bus.ctrl.dtr_ignore && !bus.ctrl.dsr_force
		&& !dtr_pin [*3] |=> !dsr_pin)
		else $error("dsr up without dtr");
	carrier_key_a: assert property (bus.ctrl.rts == HSCTL_RTS_CARRIER
		&& !rts_pin [*3] |=> !transmit_carrier)
		else $error("carrier on without rts");
	disabled_a: assert property (bus.ctrl.mode == `HSCTL_MODE_OFF
		&& !bus.ctrl.cts_force |=> !cts_pin && !transmit_carrier)
		else $error("disabled interface active");
	rts_status_a: assert property (rts_held_s |-> bus.live.rts)
		else $error("rts status stale");
	dtr_status_a: assert property (dtr_held_s |-> bus.live.dtr)
		else $error("dtr status stale");
endmodule

/* hsctl_top.sv */
`timescale 1ns/1ps
// What this block does
// - CTS setting: normal, or held asserted always.
// - DCD setting: normal, or held asserted always.
// - DTR setting: honour incoming line, or ignore it.
// - RTS setting: normal, keys carrier, or ignored.
// - Interface mode codes 0 to 9; 0 disables.
// - Live RTS/CTS/DCD/DTR/DSR states readable, read-only.
// - DSR setting: normal, or held asserted always.
module hsctl_top
	import hsctl_pkg::*;
#(
	parameter int ADDR_W = 4
)(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              rts_pin,
	input  wire logic              dtr_pin,
	input  wire logic              rx_carrier_ok,
	input  wire logic              tx_ready,
	input  wire logic [7:0]        test_status,
	output logic                   cts_pin,
	output logic                   dcd_pin,
	output logic                   dsr_pin,
	output logic                   transmit_carrier
);
	`include "hsctl_params.svh"

	// Two words need at least three address bits
	if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
		$error("hsctl_top: ADDR_W must be 3 to 8");
	end

	localparam logic [ADDR_W-3:0] CTRL_IDX = (ADDR_W-2)'(`HSCTL_CTRL_OFS >> 2);
	localparam logic [ADDR_W-3:0] STAT_IDX = (ADDR_W-2)'(`HSCTL_STAT_OFS >> 2);

	// Reset control word split into its fields, so a new reset value lands bit for bit
	localparam logic [31:0]    CTRL_RST_W = `HSCTL_CTRL_RST;
	localparam hsctl_ctrl_type CTRL_RST   = '{
		dsr_force:  CTRL_RST_W[`HSCTL_DSR_BIT],
		dtr_ignore: CTRL_RST_W[`HSCTL_DTR_BIT],
		dcd_force:  CTRL_RST_W[`HSCTL_DCD_BIT],
		cts_force:  CTRL_RST_W[`HSCTL_CTS_BIT],
		rts:        hsctl_rts_type'(CTRL_RST_W[`HSCTL_RTS_LSB +: 2]),
		mode:       CTRL_RST_W[`HSCTL_MODE_LSB +: 4]
	};

	typedef struct packed {
		hsctl_ctrl_type    ctrl;
		logic              aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic              w_held;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} hsctl_top_type;

	hsctl_top_type  r, nxt;
	hsctl_line_if   lif ();
	logic [31:0]    ctrl_word;
	logic [31:0]    stat_word;
	logic [31:0]    merged;
	hsctl_ctrl_type cand;

	// Control and status words as software sees them
	always_comb begin
		ctrl_word = '0;
		ctrl_word[`HSCTL_MODE_LSB +: 4] = r.ctrl.mode;
		ctrl_word[`HSCTL_RTS_LSB +: 2]  = r.ctrl.rts;
		ctrl_word[`HSCTL_CTS_BIT]       = r.ctrl.cts_force;
		ctrl_word[`HSCTL_DCD_BIT]       = r.ctrl.dcd_force;
		ctrl_word[`HSCTL_DTR_BIT]       = r.ctrl.dtr_ignore;
		ctrl_word[`HSCTL_DSR_BIT]       = r.ctrl.dsr_force;
		stat_word = '0;
		stat_word[`HSCTL_ST_RTS_BIT]    = lif.live.rts;
		stat_word[`HSCTL_ST_CTS_BIT]    = lif.live.cts;
		stat_word[`HSCTL_ST_DCD_BIT]    = lif.live.dcd;
		stat_word[`HSCTL_ST_DTR_BIT]    = lif.live.dtr;
		stat_word[`HSCTL_ST_DSR_BIT]    = lif.live.dsr;
		stat_word[`HSCTL_ST_EN_BIT]     = r.ctrl.mode != `HSCTL_MODE_OFF;
		stat_word[`HSCTL_ST_TEST_LSB +: 8] = test_status;
	end

	// Byte-lane merge of a pending write into the control word
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			merged[i*8 +: 8] = r.wstrb[i] ? r.wdata[i*8 +: 8] : ctrl_word[i*8 +: 8];
		end
		cand.mode       = merged[`HSCTL_MODE_LSB +: 4];
		cand.rts        = hsctl_rts_type'(merged[`HSCTL_RTS_LSB +: 2]);
		cand.cts_force  = merged[`HSCTL_CTS_BIT];
		cand.dcd_force  = merged[`HSCTL_DCD_BIT];
		cand.dtr_ignore = merged[`HSCTL_DTR_BIT];
		cand.dsr_force  = merged[`HSCTL_DSR_BIT];
	end

	// Bus slave; write performed once address and data are both held
	always_comb begin
		nxt = r;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt.aw_held = 1'b1;
			nxt.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt.w_held = 1'b1;
			nxt.wdata  = s_axi_wdata;
			nxt.wstrb  = s_axi_wstrb;
		end
		if (r.aw_held && r.w_held) begin
			nxt.aw_held = 1'b0;
			nxt.w_held  = 1'b0;
			nxt.bvalid  = 1'b1;
			if (r.awaddr[ADDR_W-1:2] == CTRL_IDX) begin
				// Illegal codes refused whole, so no half-applied setting
				if (cand.mode > `HSCTL_MODE_MAX || merged[`HSCTL_RTS_LSB +: 2] == 2'h3) begin
					nxt.bresp = `HSCTL_RESP_SLVERR;
				end else begin
					nxt.ctrl  = cand;
					nxt.bresp = `HSCTL_RESP_OKAY;
				end
			end else if (r.awaddr[ADDR_W-1:2] == STAT_IDX) begin
				nxt.bresp = `HSCTL_RESP_SLVERR;
			end else begin
				nxt.bresp = `HSCTL_RESP_DECERR;
			end
		end
		if (r.bvalid && s_axi_bready) begin
			nxt.bvalid = 1'b0;
		end
		if (r.rvalid && s_axi_rready) begin
			nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt.rvalid = 1'b1;
			if (s_axi_araddr[ADDR_W-1:2] == CTRL_IDX) begin
				nxt.rdata = ctrl_word;
				nxt.rresp = `HSCTL_RESP_OKAY;
			end else if (s_axi_araddr[ADDR_W-1:2] == STAT_IDX) begin
				nxt.rdata = stat_word;
				nxt.rresp = `HSCTL_RESP_OKAY;
			end else begin
				nxt.rdata = '0;
				nxt.rresp = `HSCTL_RESP_DECERR;
			end
		end
	end

	// Reset leaves the interface disabled and nothing forced
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '{ctrl: CTRL_RST, default: '0};
		end else begin
			r <= nxt;
		end
	end

	assign s_axi_awready = !r.aw_held && !r.bvalid;
	assign s_axi_wready  = !r.w_held && !r.bvalid;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign lif.ctrl      = r.ctrl;

	hsctl_lines u_lines (
		.aclk             (aclk),
		.aresetn          (aresetn),
		.rts_pin          (rts_pin),
		.dtr_pin          (dtr_pin),
		.rx_carrier_ok    (rx_carrier_ok),
		.tx_ready         (tx_ready),
		.bus              (lif.lines),
		.cts_pin          (cts_pin),
		.dcd_pin          (dcd_pin),
		.dsr_pin          (dsr_pin),
		.transmit_carrier (transmit_carrier)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	mode_range_a: assert property (r.ctrl.mode <= `HSCTL_MODE_MAX)
		else $error("mode code out of range");
	bad_mode_a: assert property (r.aw_held && r.w_held && !r.bvalid
		&& r.awaddr[ADDR_W-1:2] == CTRL_IDX && cand.mode > `HSCTL_MODE_MAX
		|=> s_axi_bresp == `HSCTL_RESP_SLVERR && $stable(r.ctrl))
		else $error("bad mode accepted");
	force_path_a: assert property (r.aw_held && r.w_held && !r.bvalid
		&& r.awaddr[ADDR_W-1:2] == CTRL_IDX && cand.mode <= `HSCTL_MODE_MAX
		&& merged[`HSCTL_RTS_LSB +: 2] != 2'h3 && cand.cts_force
		|=> ##1 cts_pin)
		else $error("forced cts late");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
endmodule

/* hsctl_dte.sv */
`timescale 1ns/1ps
// Terminal side: drives request and ready lines, sees the answer lines
module hsctl_dte (
	input  wire logic aclk,
	input  wire logic rts_want,
	input  wire logic dtr_want,
	input  wire logic cts_pin,
	input  wire logic dcd_pin,
	input  wire logic dsr_pin,
	output logic      rts_pin,
	output logic      dtr_pin
);
	// Lines move one clock after the bench asks, like a real terminal
	always_ff @(posedge aclk) begin
		rts_pin <= rts_want;
		dtr_pin <= dtr_want;
	end
endmodule

/* hsctl_top_bench.sv */
`timescale 1ns/1ps
module hsctl_top_bench;
	import hsctl_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  strb = 4'hf;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [3:0]  araddr = 4'h0;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        rts_want = 1'b0;
	logic        dtr_want = 1'b0;
	logic        rts_pin;
	logic        dtr_pin;
	logic        car = 1'b0;
	logic        txr = 1'b0;
	logic [7:0]  tst = 8'h5a;
	logic        cts_pin;
	logic        dcd_pin;
	logic        dsr_pin;
	logic        transmit_carrier;
	int          n_fail = 0;
	int          n_checks = 0;
	logic [31:0] d;
	logic [1:0]  r;
	logic [3:0]  e;
	logic [31:0] tbl [8] = '{32'h100, 32'h200, 32'h800, 32'h1, 32'h11, 32'h21, 32'h401, 32'h421};

	// 40 MHz clock
	always #12.5 aclk = ~aclk;

	hsctl_top #(.ADDR_W(4)) dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rts_pin(rts_pin), .dtr_pin(dtr_pin),
		.rx_carrier_ok(car), .tx_ready(txr), .test_status(tst),
		.cts_pin(cts_pin), .dcd_pin(dcd_pin), .dsr_pin(dsr_pin),
		.transmit_carrier(transmit_carrier)
	);

	hsctl_dte dte_u (
		.aclk(aclk), .rts_want(rts_want), .dtr_want(dtr_want), .cts_pin(cts_pin),
		.dcd_pin(dcd_pin), .dsr_pin(dsr_pin), .rts_pin(rts_pin), .dtr_pin(dtr_pin)
	);

	// Expected {cts, dcd, dsr, carrier} from control word and line levels
	function automatic logic [3:0] exp_lines(input logic [31:0] c, input logic rt, dt0);
		logic en;
		logic dt;
		en = (c[3:0] != 4'h0);
		dt = dt0 | c[10];
		exp_lines = {c[8] | (en & dt & (rt | (c[5:4] == 2'h2)) & txr), c[9] | (en & car),
			c[11] | (en & dt), en & dt & ((c[5:4] != 2'h1) | rt)};
	endfunction

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Ready is sampled on the falling edge, so each release lands after its taking edge
	task automatic wr(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] resp);
		logic ah, wh, bh, done;
		done = 1'b0;
		resp = 2'h1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid && bready;
			if (bh)
				resp = bresp;
			@(posedge aclk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			n_fail++;
			conclude();
		end
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
		logic ah, rh, done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(negedge aclk);
			ah = arvalid && arready;
			rh = rvalid && rready;
			dat = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ah)
				arvalid <= 1'b0;
			if (rh) begin
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			n_fail++;
			conclude();
		end
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h0, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, 32'h0);
		// Lines are looked at mid-cycle, never in the edge that launches them
		@(negedge aclk);
		chk({28'h0, cts_pin, dcd_pin, dsr_pin, transmit_carrier}, 32'h0);
		@(posedge aclk);
		rts_want <= 1'b1;
		dtr_want <= 1'b1;
		car <= 1'b1;
		txr <= 1'b1;
		// Every mode code, then the codes just beyond the legal range
		for (int m = 0; m < 10; m++) begin
			wr(4'h0, 32'(m), r);
			chk({30'h0, r}, 32'h0);
			rd(4'h0, d, r);
			chk(d, 32'(m));
			chk({30'h0, r}, 32'h0);
			@(negedge aclk);
			e = exp_lines(32'(m), 1'b1, 1'b1);
			chk({28'h0, cts_pin, dcd_pin, dsr_pin, transmit_carrier}, 32'(e));
		end
		wr(4'h0, 32'ha, r);
		chk({30'h0, r}, 32'h2);
		wr(4'h0, 32'h31, r);
		chk({30'h0, r}, 32'h2);
		rd(4'h0, d, r);
		chk(d, 32'h9);
		// Each setting against every RTS/DTR/ready combination, carrier opposite ready; lines checked one edge after
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < 8; p++) begin
				rts_want <= p[0];
				dtr_want <= p[1];
				txr <= p[2];
				car <= ~p[2];
				repeat (6) @(posedge aclk);
				wr(4'h0, tbl[c], r);
				@(negedge aclk);
				e = exp_lines(tbl[c], p[0], p[1]);
				chk({28'h0, cts_pin, dcd_pin, dsr_pin, transmit_carrier}, 32'(e));
				rd(4'h4, d, r);
				chk(d, {16'h0, tst, 2'h0, tbl[c][3:0] != 4'h0, e[1], p[1], e[2], e[3], p[0]});
			end
		end
		// One byte lane only: force bits change, mode and request setting are kept
		strb <= 4'h2;
		wr(4'h0, 32'h0000_0900, r);
		strb <= 4'hf;
		chk({30'h0, r}, 32'h0);
		rd(4'h0, d, r);
		chk(d, 32'h921);
		// Status is read-only; unmapped place answers decode error
		wr(4'h4, 32'hffff_ffff, r);
		chk({30'h0, r}, 32'h2);
		rd(4'h8, d, r);
		chk({d[31:2], r}, 32'h3);
		conclude();
	end
endmodule
